// file: hdl/fmab_top.sv
`timescale 1ns/100ps
`include "fmab_defines.svh"

// What this block does
// - normal mode multiplies 19 by 18 bits and may add or subtract a 48-bit value.
// - dual mode gives an 11 by 10 and an 8 by 8 product, each with its own 24-bit add or subtract.
// - quad mode gives a 7 by 6 and three 4 by 4 products, each with its own 12-bit add or subtract.
// - float mode does a brain-float multiply and adds, subtracts or accumulates, truncating at alignment and again at the final sum.
// - a 4-bit right shift amount shifts one, two or four lanes according to the integer mode; the float result is not shifted.
// - integer operands are read as signed or unsigned following one signedness setting.
// - the multiplier operands come from the a and b data inputs.
// - a setting chooses between forwarding the product and sending it through the adder.
// - accumulate adds each new product to, or with subtract set subtracts it from, a running total kept in the block.
module fmab_top (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     op_en,
    input  wire fmab_pkg::fmab_mode_type  mode,
    input  wire logic                     operand_signed,
    input  wire logic                     use_addsub,
    input  wire logic                     subtract,
    input  wire logic                     accumulate,
    input  wire logic [`FMAB_SH_W-1:0]    shift_amt,
    input  wire logic [`FMAB_A_W-1:0]     a_in,
    input  wire logic [`FMAB_B_W-1:0]     b_in,
    input  wire logic [`FMAB_C_W-1:0]     c_in,
    output logic      [`FMAB_C_W-1:0]     result_ff,
    output logic      [`FMAB_C_W-1:0]     total_ff,
    output logic                          result_valid_ff
);

    // ************************************************************
    // adder source selection
    // ************************************************************
    logic [`FMAB_C_W-1:0] addend;
    logic                 sub_eff;

    always_comb begin
        if (accumulate) begin
            addend = total_ff;
        end else if (use_addsub) begin
            addend = c_in;
        end else begin
            addend = '0;
        end
    end

    // without the adder the product passes unchanged
    assign sub_eff = subtract & (use_addsub | accumulate);

    // ************************************************************
    // integer lanes
    // ************************************************************
    logic [47:0] n_sum, n_sh;
    logic [23:0] d_sum [2];
    logic [23:0] d_sh  [2];
    logic [11:0] q_sum [4];
    logic [11:0] q_sh  [4];

    fmab_lane #(.AW(19), .BW(18), .RW(`FMAB_C_W)) u_normal (
        .a         (a_in),
        .b         (b_in),
        .addend    (addend),
        .is_signed (operand_signed),
        .subtract  (sub_eff),
        .shift_amt (shift_amt),
        .sum       (n_sum),
        .shifted   (n_sh)
    );

    fmab_lane #(.AW(11), .BW(10), .RW(`FMAB_DUAL_RW)) u_dual0 (
        .a         (a_in[10:0]),
        .b         (b_in[9:0]),
        .addend    (addend[23:0]),
        .is_signed (operand_signed),
        .subtract  (sub_eff),
        .shift_amt (shift_amt),
        .sum       (d_sum[0]),
        .shifted   (d_sh[0])
    );

    fmab_lane #(.AW(8), .BW(8), .RW(`FMAB_DUAL_RW)) u_dual1 (
        .a         (a_in[18:11]),
        .b         (b_in[17:10]),
        .addend    (addend[47:24]),
        .is_signed (operand_signed),
        .subtract  (sub_eff),
        .shift_amt (shift_amt),
        .sum       (d_sum[1]),
        .shifted   (d_sh[1])
    );

    fmab_lane #(.AW(7), .BW(6), .RW(`FMAB_QUAD_RW)) u_quad0 (
        .a         (a_in[6:0]),
        .b         (b_in[5:0]),
        .addend    (addend[11:0]),
        .is_signed (operand_signed),
        .subtract  (sub_eff),
        .shift_amt (shift_amt),
        .sum       (q_sum[0]),
        .shifted   (q_sh[0])
    );

    genvar g;
    generate
        for (g = 1; g < 4; g++) begin : gen_quad
            fmab_lane #(.AW(4), .BW(4), .RW(`FMAB_QUAD_RW)) u_quad (
                .a         (a_in[4*g+6 -: 4]),
                .b         (b_in[4*g+5 -: 4]),
                .addend    (addend[12*g+11 -: 12]),
                .is_signed (operand_signed),
                .subtract  (sub_eff),
                .shift_amt (shift_amt),
                .sum       (q_sum[g]),
                .shifted   (q_sh[g])
            );
        end
    endgenerate

    // ************************************************************
    // brain-float fused multiply-add
    // ************************************************************
    // product is exact; bits of the smaller operand shifted out at alignment are dropped, and the final sum is truncated to single float
    logic              p_sign, c_sign, p_zero, c_zero;
    logic signed [11:0] p_exp, c_exp, big_exp, r_exp;
    logic [24:0]       p_man, c_man, big_man, small_man;
    logic              big_sign, small_sign;
    logic [15:0]       p_raw;
    logic [11:0]       diff;
    logic [26:0]       mag;
    logic [4:0]        lead;
    logic              r_sign;
    logic [31:0]       fp_out;

    assign p_raw  = {1'b1, a_in[6:0]} * {1'b1, b_in[6:0]};
    assign p_zero = (a_in[14:7] == 8'h00) | (b_in[14:7] == 8'h00);
    assign p_sign = a_in[15] ^ b_in[15] ^ sub_eff;
    assign p_exp  = 12'(a_in[14:7]) + 12'(b_in[14:7]) - 12'(`FMAB_FP_BIAS);
    assign p_man  = p_zero ? 25'h0000000 : {p_raw, 9'h000};
    assign c_zero = (addend[30:23] == 8'h00);
    assign c_sign = addend[31];
    assign c_exp  = 12'(addend[30:23]);
    assign c_man  = c_zero ? 25'h0000000 : {2'b01, addend[22:0]};

    always_comb begin
        if (p_zero || (!c_zero && c_exp > p_exp)) begin
            big_exp    = c_exp;
            big_man    = c_man;
            big_sign   = c_sign;
            small_man  = p_man;
            small_sign = p_sign;
            diff       = p_zero ? 12'h0ff : 12'(c_exp - p_exp);
        end else begin
            big_exp    = p_exp;
            big_man    = p_man;
            big_sign   = p_sign;
            small_man  = c_man;
            small_sign = c_sign;
            diff       = c_zero ? 12'h0ff : 12'(p_exp - c_exp);
        end
    end

    always_comb begin
        logic [24:0] aligned;
        aligned = (diff > 12'd24) ? 25'h0000000 : (small_man >> diff[4:0]);
        if (big_sign == small_sign) begin
            mag    = 27'(big_man) + 27'(aligned);
            r_sign = big_sign;
        end else if (big_man >= aligned) begin
            mag    = 27'(big_man) - 27'(aligned);
            r_sign = big_sign;
        end else begin
            mag    = 27'(aligned) - 27'(big_man);
            r_sign = small_sign;
        end
    end

    always_comb begin
        lead = 5'h00;
        for (int i = 0; i < 27; i++) begin
            if (mag[i]) begin
                lead = 5'(i);
            end
        end
    end

    always_comb begin
        logic [26:0] norm;
        norm  = (lead >= 5'd23) ? (mag >> (lead - 5'd23)) : (mag << (5'd23 - lead));
        r_exp = big_exp + 12'(lead) - 12'd23;
        if (mag == 27'h0000000 || r_exp <= 12'sd0) begin
            fp_out = 32'h00000000;
        end else if (r_exp >= 12'sd255) begin
            fp_out = {r_sign, 8'hff, 23'h000000};
        end else begin
            fp_out = {r_sign, r_exp[7:0], norm[22:0]};
        end
    end

    // ************************************************************
    // mode selection of result and new total
    // ************************************************************
    logic [47:0] nxt_result, nxt_total;

    always_comb begin
        unique case (mode)
            fmab_pkg::FMAB_NORMAL: begin
                nxt_result = n_sh;
                nxt_total  = n_sum;
            end
            fmab_pkg::FMAB_DUAL: begin
                nxt_result = {d_sh[1], d_sh[0]};
                nxt_total  = {d_sum[1], d_sum[0]};
            end
            fmab_pkg::FMAB_QUAD: begin
                nxt_result = {q_sh[3], q_sh[2], q_sh[1], q_sh[0]};
                nxt_total  = {q_sum[3], q_sum[2], q_sum[1], q_sum[0]};
            end
            fmab_pkg::FMAB_FLOAT: begin
                nxt_result = {16'h0000, fp_out};
                nxt_total  = {16'h0000, fp_out};
            end
        endcase
    end

    // ************************************************************
    // output and running total registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_ff <= '0;
        end else if (op_en) begin
            result_ff <= nxt_result;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            total_ff <= '0;
        end else if (op_en) begin
            total_ff <= nxt_total;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_valid_ff <= 1'b0;
        end else begin
            result_valid_ff <= op_en;
        end
    end

endmodule : fmab_top

// file: hdl/fmab_defines.svh
`ifndef FMAB_DEFINES_SVH
`define FMAB_DEFINES_SVH

// ************************************************************
// operand and result widths
// ************************************************************
`define FMAB_A_W        19
`define FMAB_B_W        18
`define FMAB_C_W        48
`define FMAB_SH_W       4

// ************************************************************
// lane result widths and float format constants
// ************************************************************
`define FMAB_DUAL_RW    24
`define FMAB_QUAD_RW    12
`define FMAB_BF_W       16
`define FMAB_FP_W       32
`define FMAB_FP_BIAS    127

`endif

// file: hdl/fmab_pkg.sv
package fmab_pkg;

    typedef enum logic [1:0] {
        FMAB_NORMAL = 2'b00,
        FMAB_DUAL   = 2'b01,
        FMAB_QUAD   = 2'b10,
        FMAB_FLOAT  = 2'b11
    } fmab_mode_type;

endpackage : fmab_pkg

// file: hdl/fmab_lane.sv
`timescale 1ns/100ps

// one integer lane: multiply, add or subtract, right shift
module fmab_lane #(
    parameter int AW = 19,
    parameter int BW = 18,
    parameter int RW = 48
) (
    input  wire logic [AW-1:0] a,
    input  wire logic [BW-1:0] b,
    input  wire logic [RW-1:0] addend,
    input  wire logic          is_signed,
    input  wire logic          subtract,
    input  wire logic [3:0]    shift_amt,
    output logic      [RW-1:0] sum,
    output logic      [RW-1:0] shifted
);

    localparam int PW = AW + BW + 2;
    localparam int XW = (PW > RW) ? PW : RW;

    logic signed [AW:0]    ax;
    logic signed [BW:0]    bx;
    logic signed [XW-1:0]  prod_x;
    logic        [RW-1:0]  prod;

    // extend by one bit so one signed multiplier serves both kinds
    assign ax      = {is_signed & a[AW-1], a};
    assign bx      = {is_signed & b[BW-1], b};
    assign prod_x  = XW'(ax) * XW'(bx);
    assign prod    = prod_x[RW-1:0];
    assign sum     = subtract ? (addend - prod) : (addend + prod);
    // arithmetic shift for signed operands, logical otherwise
    assign shifted = is_signed ? RW'($signed(sum) >>> shift_amt)
                               : (sum >> shift_amt);

endmodule : fmab_lane

// file: sim/fmab_top_asserts.sv
`timescale 1ns/100ps
module fmab_top_asserts (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    op_en,
    input wire fmab_pkg::fmab_mode_type mode,
    input wire logic                    operand_signed,
    input wire logic                    use_addsub,
    input wire logic                    subtract,
    input wire logic                    accumulate,
    input wire logic [3:0]              shift_amt,
    input wire logic [18:0]             a_in,
    input wire logic [17:0]             b_in,
    input wire logic [47:0]             c_in,
    input wire logic [47:0]             result_ff,
    input wire logic [47:0]             total_ff,
    input wire logic                    result_valid_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ***
    // one unsigned normal-mode operation taken
    // ***
    sequence s_norm_uns;
        op_en && mode == fmab_pkg::FMAB_NORMAL && !operand_signed;
    endsequence
    chk_valid_pulse: assert property (op_en |=> result_valid_ff) else $error("no valid after op");
    chk_valid_quiet: assert property (!op_en |=> !result_valid_ff) else $error("valid without op");
    chk_idle_hold:
        assert property (!op_en |=> $stable(result_ff) && $stable(total_ff)) else $error("moved while idle");
    chk_reset_clear:
        assert property (disable iff (1'b0) !nrst |=> result_ff == 48'h0 && total_ff == 48'h0 && !result_valid_ff)
        else $error("not cleared by reset");
    chk_forward_product:
        assert property (s_norm_uns ##0 (!use_addsub && !accumulate)
            |=> total_ff == {29'h0, $past(a_in)} * {30'h0, $past(b_in)}) else $error("bad product");
    chk_acc_total:
        assert property (s_norm_uns ##0 (accumulate && !subtract)
            |=> total_ff == $past(total_ff) + {29'h0, $past(a_in)} * {30'h0, $past(b_in)}) else $error("bad total");
    chk_shift_logical:
        assert property (s_norm_uns |=> result_ff == total_ff >> $past(shift_amt)) else $error("bad shift");
    chk_float_high:
        assert property (op_en && mode == fmab_pkg::FMAB_FLOAT |=> result_ff[47:32] == 16'h0) else $error("float high");
endmodule : fmab_top_asserts

bind fmab_top fmab_top_asserts fmab_top_asserts_inst (
    .clk(clk), .nrst(nrst), .op_en(op_en), .mode(mode), .operand_signed(operand_signed),
    .use_addsub(use_addsub), .subtract(subtract), .accumulate(accumulate), .shift_amt(shift_amt),
    .a_in(a_in), .b_in(b_in), .c_in(c_in), .result_ff(result_ff), .total_ff(total_ff),
    .result_valid_ff(result_valid_ff)
);

// file: sim/fmab_fabric_user.sv
`timescale 1ns/100ps
// ***
// fabric consumer: latches each valid result
// ***
module fmab_fabric_user (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        result_valid_ff,
    input  wire logic [47:0] result_ff,
    output logic      [47:0] seen_ff,
    output logic      [15:0] n_ops_ff
);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            seen_ff  <= 48'h0;
            n_ops_ff <= 16'h0;
        end else if (result_valid_ff) begin
            seen_ff  <= result_ff;
            n_ops_ff <= n_ops_ff + 16'h1;
        end
    end
endmodule : fmab_fabric_user

// file: sim/test_fabric_multiply_accumulate_block.sv
`timescale 1ns/100ps
module test_fabric_multiply_accumulate_block;
    logic                    clk;
    logic                    nrst;
    logic                    op_en;
    fmab_pkg::fmab_mode_type mode;
    logic [3:0]              fl;
    logic [3:0]              shift_amt;
    logic [18:0]             a_in;
    logic [17:0]             b_in;
    logic [47:0]             c_in;
    logic [47:0]             result_ff;
    logic [47:0]             total_ff;
    logic                    result_valid_ff;
    logic [47:0]             seen_ff;
    logic [15:0]             n_ops_ff;
    int                      err_count;
    int                      n_tests;
    int                      n_ops;
    int                      cycles;

    fmab_top fmab_top_inst (.clk(clk), .nrst(nrst), .op_en(op_en), .mode(mode), .operand_signed(fl[3]),
        .use_addsub(fl[2]), .subtract(fl[1]), .accumulate(fl[0]), .shift_amt(shift_amt), .a_in(a_in),
        .b_in(b_in), .c_in(c_in), .result_ff(result_ff), .total_ff(total_ff), .result_valid_ff(result_valid_ff));
    fmab_fabric_user fmab_fabric_user_inst (.clk(clk), .nrst(nrst), .result_valid_ff(result_valid_ff),
        .result_ff(result_ff), .seen_ff(seen_ff), .n_ops_ff(n_ops_ff));

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // flags f = {signed, addsub, subtract, accumulate}, one signedness for all lanes
    task automatic op(input logic [1:0] m, input logic [3:0] f, input logic [3:0] sh,
                      input logic [18:0] a, input logic [17:0] b, input logic [47:0] c);
        op_en = 1'b1;
        mode = fmab_pkg::fmab_mode_type'(m);
        fl = f;
        shift_amt = sh;
        a_in = a;
        b_in = b;
        c_in = c;
        n_ops++;
        @(posedge clk);
        #1;
    endtask : op

    task automatic idle();
        op_en = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle

    task automatic t_normal();
        op(2'h0, 4'h4, 4'h0, 19'h3, 18'h5, 48'ha);
        chk(result_ff, 48'h19);
        chk({47'h0, result_valid_ff}, 48'h1);
        op(2'h0, 4'h1, 4'h0, 19'h3, 18'h5, 48'h0);
        chk(total_ff, 48'h28);
        op(2'h0, 4'he, 4'h2, 19'h7fffd, 18'h5, 48'h64);
        chk(result_ff, 48'h1c);
        op(2'h0, 4'h8, 4'h1, 19'h7fffd, 18'h5, 48'h0);
        chk(result_ff, 48'hfffffffffff8);
        op(2'h0, 4'h4, 4'h4, 19'h0, 18'h0, 48'h800000000000);
        chk(result_ff, 48'h080000000000);
        chk(total_ff, 48'h800000000000);
        op(2'h0, 4'h0, 4'h0, 19'h7ffff, 18'h3ffff, 48'h1);
        chk(result_ff, 48'h7ffff * 48'h3ffff);
        idle();
        idle();
        chk({47'h0, result_valid_ff}, 48'h0);
        chk(result_ff, 48'h7ffff * 48'h3ffff);
    endtask : t_normal

    task automatic t_lanes();
        op(2'h1, 4'h4, 4'h0, {8'h2, 11'h1}, {8'h3, 10'h1}, {24'h5, 24'hffffff});
        chk(result_ff, {24'hb, 24'h0});
        op(2'h1, 4'h8, 4'h1, {8'h4, 11'h7fe}, {8'h4, 10'h3}, 48'h0);
        chk(result_ff, {24'h8, 24'hfffffd});
        op(2'h2, 4'h8, 4'h1, {4'h7, 4'h2, 4'hf, 7'h03}, {4'h7, 4'h2, 4'h1, 6'h02}, 48'h0);
        chk(result_ff, {12'h018, 12'h002, 12'hfff, 12'h003});
        chk(total_ff, {12'h031, 12'h004, 12'hfff, 12'h006});
    endtask : t_lanes

    task automatic t_float();
        op(2'h3, 4'h4, 4'h0, 19'h3fc0, 18'h4000, 48'h3f800000);
        chk(result_ff, 48'h40800000);
        op(2'h3, 4'h6, 4'h0, 19'h3fc0, 18'h4000, 48'h3f800000);
        chk(result_ff, 48'hc0000000);
        op(2'h3, 4'h1, 4'h0, 19'h3fc0, 18'h4000, 48'h0);
        chk(total_ff, 48'h3f800000);
        idle();
        idle();
        chk(seen_ff, 48'h3f800000);
        chk({32'h0, n_ops_ff}, 48'(n_ops));
    endtask : t_float

    task automatic t_reset();
        nrst = 1'b0;
        @(posedge clk);
        #1;
        chk(result_ff, 48'h0);
        chk(total_ff, 48'h0);
        chk({47'h0, result_valid_ff}, 48'h0);
        nrst = 1'b1;
        op(2'h0, 4'h1, 4'h0, 19'h3, 18'h5, 48'h0);
        chk(total_ff, 48'hf);
    endtask : t_reset

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        {nrst, op_en, fl, shift_amt, a_in, b_in, c_in} = '0;
        mode = fmab_pkg::FMAB_NORMAL;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_normal();
        t_lanes();
        t_float();
        t_reset();
        end_of_test();
    end
endmodule : test_fabric_multiply_accumulate_block
